/* hw/pts_pkg.sv */
package pts_pkg;
	// ---------------------------------------------------------------
	// Register map, word addresses on the plain register port
	// ---------------------------------------------------------------
	localparam int PTS_AW = 8;
	localparam logic [7:0] PTS_ADDR_CTRL = 8'h00;
	localparam logic [7:0] PTS_ADDR_CFG = 8'h01;
	localparam logic [7:0] PTS_ADDR_LIM0 = 8'h02;
	localparam logic [7:0] PTS_ADDR_LIM3 = 8'h05;
	localparam logic [7:0] PTS_ADDR_WDLIM = 8'h06;
	localparam logic [7:0] PTS_ADDR_STAT = 8'h07;
	localparam logic [7:0] PTS_ADDR_QUE0 = 8'h08;
	localparam logic [7:0] PTS_ADDR_QUE7 = 8'h0f;
	// ---------------------------------------------------------------
	// Control/status and configuration field positions and register reset values
	// ---------------------------------------------------------------
	localparam int PTS_B_EN = 15;
	localparam int PTS_B_SIDL = 13;
	localparam int PTS_B_TOGL = 12;
	localparam int PTS_B_SWT = 10;
	localparam int PTS_B_SSEN = 9;
	localparam int PTS_B_IVIS = 8;
	localparam int PTS_B_RUN = 7;
	localparam int PTS_B_WDTO = 6;
	localparam int PTS_B_EDGE = 0;
	localparam int PTS_PW_LSB = 4;
	localparam logic [15:0] PTS_CTRL_RST = 16'h0000;
	localparam logic [15:0] PTS_CTRL_WMASK = 16'hb383;
	localparam logic [7:0] PTS_PW_RST = 8'h01;
	localparam logic [15:0] PTS_LIM_RST = 16'h0000;
	localparam logic [15:0] PTS_WDLIM_RST = 16'h0000;
	// ---------------------------------------------------------------
	// Step opcodes, upper nibble of a queue entry
	// ---------------------------------------------------------------
	localparam logic [3:0] PTS_OP_CTRL = 4'h0;
	localparam logic [3:0] PTS_OP_WAITIN = 4'h1;
	localparam logic [3:0] PTS_OP_TRIG = 4'h2;
	localparam logic [3:0] PTS_OP_TIMER = 4'h3;
	localparam logic [3:0] PTS_OP_LOOP0 = 4'h4;
	localparam logic [3:0] PTS_OP_LOOP1 = 4'h5;
	localparam logic [3:0] PTS_OP_IRQ = 4'h6;
	localparam logic [3:0] PTS_OP_JUMP = 4'h7;
	localparam logic [3:0] PTS_CTRL_SWWAIT = 4'h1;
	typedef enum logic [3:0] {
		PTS_ST_IDLE = 4'b0001,
		PTS_ST_FETCH = 4'b0010,
		PTS_ST_EXEC = 4'b0100,
		PTS_ST_WAIT = 4'b1000
	} pts_state_t;
endpackage : pts_pkg

/* hw/pts_queue_mem.sv */
`timescale 1ns/1ns
// The step queue. Both read ports are registered; port b also carries the
// register read data so that the bus answer leaves a single flip-flop.
module pts_queue_mem #(
	parameter int DEPTH = 8,
	parameter int DW = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic we_i,
	input wire logic [$clog2(DEPTH)-1:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [$clog2(DEPTH)-1:0] raddr_a_i,
	output logic [7:0] rdata_a_o,
	input wire logic rd_b_i,
	input wire logic sel_b_i,
	input wire logic [$clog2(DEPTH)-1:0] raddr_b_i,
	input wire logic [DW-1:0] other_b_i,
	output logic [DW-1:0] rdata_b_o
);
	logic [7:0] mem_q [DEPTH];

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < DEPTH; i++) mem_q[i] <= 8'h00;
		end else if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) rdata_a_o <= 8'h00;
		else rdata_a_o <= mem_q[raddr_a_i];
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) rdata_b_o <= '0;
		else if (!rd_b_i) rdata_b_o <= '0;
		else if (sel_b_i) rdata_b_o <= {{(DW-8){1'b0}}, mem_q[raddr_b_i]};
		else rdata_b_o <= other_b_i;
	end
endmodule : pts_queue_mem

/* hw/pts_count.sv */
`timescale 1ns/1ns
// A 16-bit up counter compared against a limit; serves as timer or loop
// counter depending on how the sequencer drives clear and increment.
module pts_count #(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic clear_i,
	input wire logic inc_i,
	input wire logic [W-1:0] limit_i,
	output logic [W-1:0] value_o,
	output logic hit_o
);
	always_ff @(posedge clk_i) begin
		if (!rstn_i) value_o <= '0;
		else if (clear_i) value_o <= '0;
		else if (inc_i) value_o <= value_o + W'(1);
	end

	assign hit_o = (value_o == limit_i);
endmodule : pts_count

/* hw/pts_sequencer.sv */
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - Eight byte-wide step entries drive all operations.
// - Two independent 16-bit interval timers for waits.
// - Two independent 16-bit loop/event limit counters.
// - Software selects rising or falling input edges.
// - Four step-driven processor interrupt outputs.
// - Single-step mode interrupts on every executed step.
// - Sequencer watchdog expiry raises an interrupt.
// - Trigger outputs go toward the peripherals.
// - Watchdog time-out flag: hardware set, resets zero.
// - Toggle mode inverts; otherwise emit a timed pulse.
// - Visibility bit makes limit reads return live counts.
// - Run bit executes steps continuously; clear stops.
// - Writing one triggers; writing zero does nothing.
module pts_sequencer
	import pts_pkg::*;
#(
	parameter int NTRIG_IN = 16,
	parameter int NTRIG_OUT = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [PTS_AW-1:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic idle_i,
	input wire logic [NTRIG_IN-1:0] trig_in_i,
	output logic [NTRIG_OUT-1:0] trig_out_o,
	output logic [3:0] irq_o,
	output logic step_irq_o,
	output logic wdt_irq_o
);
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [15:0] ctrl_q, wd_lim_q, wd_cnt_q, reg_rd;
	logic swt_q, wdto_q, edge_fall_q;
	logic [7:0] pw_q, step, pulse_cnt_q;
	logic [15:0] lim_q [4];
	pts_state_t state_q;
	logic [2:0] pc_q;
	logic [3:0] op, arg, cnt_hit, cnt_clr, cnt_inc;
	logic [15:0] cnt_val [4];
	logic [NTRIG_OUT-1:0] pulse_mask_q;
	logic [NTRIG_IN-1:0] in_s1_q, in_s2_q, in_s3_q;
	logic [NTRIG_IN-1:0] in_edge;
	logic active, wr_ctrl, wd_expire, step_done, advance, jump, swt_take, emit;

	assign wr_ctrl = wr_i && (addr_i == PTS_ADDR_CTRL);
	assign active = ctrl_q[PTS_B_EN] && ctrl_q[PTS_B_RUN] &&
		!(ctrl_q[PTS_B_SIDL] && idle_i);
	assign op = step[7:4];
	assign arg = step[3:0];

	function automatic logic is_lim(input logic [PTS_AW-1:0] a);
		return (a >= PTS_ADDR_LIM0) && (a <= PTS_ADDR_LIM3);
	endfunction : is_lim

	function automatic logic [1:0] lim_idx(input logic [PTS_AW-1:0] a);
		return 2'(a - PTS_ADDR_LIM0);
	endfunction : lim_idx
	function automatic logic is_que(input logic [PTS_AW-1:0] a);
		return (a >= PTS_ADDR_QUE0) && (a <= PTS_ADDR_QUE7);
	endfunction : is_que

	// ---------------------------------------------------------------
	// Control/status, configuration, limit and watchdog limit registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctrl_q <= PTS_CTRL_RST;
		end else begin
			if (wr_ctrl)
				ctrl_q <= wdata_i & PTS_CTRL_WMASK;
			// A watchdog expiry stops the sequence even against a write.
			if (wd_expire)
				ctrl_q[PTS_B_RUN] <= 1'b0;
		end
	end

	// Only a written one arms the trigger; the step consumes it.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) swt_q <= 1'b0;
		else if (wr_ctrl && wdata_i[PTS_B_SWT]) swt_q <= 1'b1;
		else if (swt_take) swt_q <= 1'b0;
	end

	// Hardware sets; software may clear by writing zero, and a
	// simultaneous expiry wins.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) wdto_q <= 1'b0;
		else if (wd_expire) wdto_q <= 1'b1;
		else if (wr_ctrl && !wdata_i[PTS_B_WDTO]) wdto_q <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			edge_fall_q <= 1'b0;
			pw_q <= PTS_PW_RST;
			wd_lim_q <= PTS_WDLIM_RST;
			for (int i = 0; i < 4; i++) lim_q[i] <= PTS_LIM_RST;
		end else if (wr_i) begin
			if (addr_i == PTS_ADDR_CFG) begin
				edge_fall_q <= wdata_i[PTS_B_EDGE];
				pw_q <= wdata_i[PTS_PW_LSB +: 8];
			end
			if (addr_i == PTS_ADDR_WDLIM)
				wd_lim_q <= wdata_i;
			if (is_lim(addr_i))
				lim_q[lim_idx(addr_i)] <= wdata_i;
		end
	end

	// ---------------------------------------------------------------
	// Read mux, registered in the queue memory
	// ---------------------------------------------------------------
	always_comb begin
		reg_rd = 16'h0000;
		if (addr_i == PTS_ADDR_CTRL) begin
			reg_rd = ctrl_q;
			reg_rd[PTS_B_SWT] = swt_q;
			reg_rd[PTS_B_WDTO] = wdto_q;
		end else if (addr_i == PTS_ADDR_CFG) begin
			reg_rd[PTS_B_EDGE] = edge_fall_q;
			reg_rd[PTS_PW_LSB +: 8] = pw_q;
		end else if (is_lim(addr_i)) begin
			if (ctrl_q[PTS_B_IVIS])
				reg_rd = cnt_val[lim_idx(addr_i)];
			else
				reg_rd = lim_q[lim_idx(addr_i)];
		end else if (addr_i == PTS_ADDR_WDLIM) begin
			reg_rd = ctrl_q[PTS_B_IVIS] ? wd_cnt_q : wd_lim_q;
		end else if (addr_i == PTS_ADDR_STAT) begin
			reg_rd = {8'h00, state_q, 1'b0, pc_q};
		end
	end

	pts_queue_mem #(
		.DEPTH(8),
		.DW(16)
	) u_queue (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.we_i(wr_i && is_que(addr_i)),
		.waddr_i(addr_i[2:0]),
		.wdata_i(wdata_i[7:0]),
		.raddr_a_i(pc_q),
		.rdata_a_o(step),
		.rd_b_i(rd_i),
		.sel_b_i(is_que(addr_i)),
		.raddr_b_i(addr_i[2:0]),
		.other_b_i(reg_rd),
		.rdata_b_o(rdata_o)
	);

	// ---------------------------------------------------------------
	// Trigger inputs: synchroniser and edge detect
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) {in_s3_q, in_s2_q, in_s1_q} <= '0;
		else {in_s3_q, in_s2_q, in_s1_q} <= {in_s2_q, in_s1_q, trig_in_i};
	end

	assign in_edge = edge_fall_q ? (in_s3_q & ~in_s2_q) :
		(~in_s3_q & in_s2_q);

	// ---------------------------------------------------------------
	// Timers (0, 1) and limit counters (2, 3)
	// ---------------------------------------------------------------
	for (genvar g = 0; g < 4; g++) begin : g_cnt
		pts_count #(
			.W(16)
		) u_cnt (
			.clk_i(clk_i),
			.rstn_i(rstn_i),
			.clear_i(cnt_clr[g]),
			.inc_i(cnt_inc[g]),
			.limit_i(lim_q[g]),
			.value_o(cnt_val[g]),
			.hit_o(cnt_hit[g])
		);
	end

	// ---------------------------------------------------------------
	// Step decode
	// ---------------------------------------------------------------
	always_comb begin
		step_done = 1'b0;
		jump = 1'b0;
		emit = 1'b0;
		swt_take = 1'b0;
		cnt_clr = 4'h0;
		cnt_inc = 4'h0;
		if (state_q == PTS_ST_EXEC) begin
			case (op)
				PTS_OP_CTRL: step_done = (arg != PTS_CTRL_SWWAIT);
				PTS_OP_WAITIN: step_done = 1'b0;
				PTS_OP_TRIG: begin
					// A pulse step waits while the previous pulse is out.
					emit = ctrl_q[PTS_B_TOGL] || (pulse_cnt_q == 8'h00);
					step_done = emit;
				end
				PTS_OP_TIMER: cnt_clr[arg[0]] = 1'b1;
				PTS_OP_LOOP0, PTS_OP_LOOP1: begin
					if (cnt_hit[{1'b1, op[0]}]) begin
						cnt_clr[{1'b1, op[0]}] = 1'b1;
						step_done = 1'b1;
					end else begin
						cnt_inc[{1'b1, op[0]}] = 1'b1;
						jump = 1'b1;
					end
				end
				PTS_OP_JUMP: jump = 1'b1;
				default: step_done = 1'b1;
			endcase
		end else if (state_q == PTS_ST_WAIT) begin
			case (op)
				PTS_OP_CTRL: begin
					swt_take = swt_q;
					step_done = swt_q;
				end
				PTS_OP_WAITIN: step_done = in_edge[arg];
				PTS_OP_TIMER: begin
					step_done = cnt_hit[arg[0]];
					cnt_inc[arg[0]] = !cnt_hit[arg[0]];
				end
				default: step_done = 1'b1;
			endcase
		end
	end

	assign advance = active && step_done && !wd_expire;

	// ---------------------------------------------------------------
	// Sequencer state machine
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_q <= PTS_ST_IDLE;
			pc_q <= 3'h0;
		end else if (!active || wd_expire) begin
			// Stopping rewinds so the next start begins at entry zero.
			state_q <= PTS_ST_IDLE;
			pc_q <= 3'h0;
		end else begin
			case (state_q)
				PTS_ST_IDLE: state_q <= PTS_ST_FETCH;
				// The queue read is registered, so fetch costs a cycle.
				PTS_ST_FETCH: state_q <= PTS_ST_EXEC;
				PTS_ST_EXEC: begin
					if (advance) begin
						pc_q <= pc_q + 3'h1;
						state_q <= PTS_ST_FETCH;
					end else if (jump) begin
						pc_q <= arg[2:0];
						state_q <= PTS_ST_FETCH;
					end else if (op != PTS_OP_TRIG) begin
						state_q <= PTS_ST_WAIT;
					end
				end
				PTS_ST_WAIT: begin
					if (advance) begin
						pc_q <= pc_q + 3'h1;
						state_q <= PTS_ST_FETCH;
					end
				end
				default: state_q <= PTS_ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Watchdog: limits the time spent on one step; zero disables it
	// ---------------------------------------------------------------
	assign wd_expire = active && (wd_lim_q != 16'h0000) &&
		(wd_cnt_q == wd_lim_q);

	always_ff @(posedge clk_i) begin
		if (!rstn_i) wd_cnt_q <= 16'h0000;
		else if (!active || advance || state_q == PTS_ST_FETCH)
			wd_cnt_q <= 16'h0000;
		else if (state_q == PTS_ST_EXEC || state_q == PTS_ST_WAIT)
			wd_cnt_q <= wd_cnt_q + 16'h0001;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) wdt_irq_o <= 1'b0;
		else wdt_irq_o <= wd_expire;
	end

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_o <= 4'h0;
			step_irq_o <= 1'b0;
		end else begin
			irq_o <= 4'h0;
			if (advance && state_q == PTS_ST_EXEC && op == PTS_OP_IRQ)
				irq_o[arg[1:0]] <= 1'b1;
			step_irq_o <= (advance || (active && jump)) &&
				ctrl_q[PTS_B_SSEN];
		end
	end

	// ---------------------------------------------------------------
	// Trigger outputs
	// ---------------------------------------------------------------
	// One shared pulse timer keeps the area small; the cost is that a
	// second pulse step waits until the first pulse has ended.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			trig_out_o <= '0;
			pulse_cnt_q <= 8'h00;
			pulse_mask_q <= '0;
		end else begin
			if (pulse_cnt_q != 8'h00) begin
				pulse_cnt_q <= pulse_cnt_q - 8'h01;
				if (pulse_cnt_q == 8'h01)
					trig_out_o <= trig_out_o & ~pulse_mask_q;
			end
			if (active && emit && ctrl_q[PTS_B_TOGL]) begin
				trig_out_o[arg] <= ~trig_out_o[arg];
			end else if (active && emit) begin
				trig_out_o[arg] <= 1'b1;
				pulse_mask_q <= '0;
				pulse_mask_q[arg] <= 1'b1;
				pulse_cnt_q <= (pw_q == 8'h00) ? 8'h01 : pw_q;
			end
		end
	end
endmodule : pts_sequencer

/* verification/pts_sequencer_properties.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Port-level checks of the trigger sequencer
// ---------------------------------------------------------------
module pts_sequencer_properties
	import pts_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [PTS_AW-1:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic [15:0] trig_out_o,
	input wire logic [3:0] irq_o,
	input wire logic step_irq_o,
	input wire logic wdt_irq_o
);
	logic en_q, togl_q, ssen_q;
	logic [7:0] pw_q;
	logic [15:0] wdl_q;
	logic [7:0] hi_q;
	// Shadows of the written settings; the watchdog never alters these bits.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			{en_q, togl_q, ssen_q} <= 3'h0;
		end else if (wr_i && addr_i == PTS_ADDR_CTRL) begin
			{en_q, togl_q, ssen_q} <= {wdata_i[15], wdata_i[12], wdata_i[9]};
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pw_q <= PTS_PW_RST;
			wdl_q <= PTS_WDLIM_RST;
		end else if (wr_i && addr_i == PTS_ADDR_CFG) begin
			pw_q <= wdata_i[11:4];
		end else if (wr_i && addr_i == PTS_ADDR_WDLIM) begin
			wdl_q <= wdata_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !trig_out_o[0]) hi_q <= 8'h00;
		else hi_q <= hi_q + 8'h01;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data present without a read");
	irq_pulse_a: assert property (|irq_o |-> en_q ##1 irq_o == 4'h0)
		else $error("step interrupt longer than one cycle or disabled");
	step_gate_a: assert property (step_irq_o |-> ssen_q)
		else $error("single-step interrupt while single-step is off");
	wdt_pulse_a: assert property (wdt_irq_o |-> wdl_q != 0 ##1 !wdt_irq_o)
		else $error("watchdog interrupt bad");
	reset_quiet_a: assert property (disable iff (1'b0) !rstn_i |=>
		(trig_out_o == 0 && irq_o == 0 && !wdt_irq_o && rdata_o == 0))
		else $error("outputs active after reset");
	stop_quiet_a: assert property ((!en_q && !$past(en_q) &&
		!$past(en_q, 2)) |-> (irq_o == 0 && !step_irq_o && !wdt_irq_o))
		else $error("sequencer active while disabled");
	pulse_width_a: assert property (($fell(trig_out_o[0]) && !togl_q) |->
		hi_q == ((pw_q == 8'h00) ? 8'h01 : pw_q))
		else $error("trigger pulse width wrong");
	toggle_one_a: assert property ((togl_q && $past(togl_q)) |->
		$countones(trig_out_o ^ $past(trig_out_o)) <= 1)
		else $error("more than one trigger output changed");
	cover property (wdt_irq_o);
	cover property (step_irq_o);
	cover property ($fell(trig_out_o[0]));
	cover property (irq_o == 4'h8);
endmodule : pts_sequencer_properties

bind pts_sequencer pts_sequencer_properties u_pts_sequencer_properties (
	.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_out_o(trig_out_o),
	.irq_o(irq_o), .step_irq_o(step_irq_o), .wdt_irq_o(wdt_irq_o));

/* verification/pts_periph_model.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Peripheral side: trigger sources the steps wait on
// ---------------------------------------------------------------
module pts_periph_model #(
	parameter int HOLD = 3
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic fall_i,
	input wire logic [15:0] kick_i,
	output logic [15:0] trig_in_o
);
	logic [15:0] act_q;
	logic [7:0] cnt_q;
	// A raised event stays up HOLD+1 cycles so the synchroniser sees it.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			act_q <= 16'h0000;
			cnt_q <= 8'h00;
		end else if (kick_i != 16'h0000) begin
			act_q <= kick_i;
			cnt_q <= 8'(HOLD);
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			act_q <= 16'h0000;
		end
	end
	assign trig_in_o = act_q ^ {16{fall_i}};
endmodule : pts_periph_model

/* verification/tb_pts_sequencer.sv */
`timescale 1ns/1ns
module tb_pts_sequencer
	import pts_pkg::*;
;
	logic clk_i, rstn_i, wr_i, rd_i, idle_i, fall;
	logic [7:0] addr_i;
	logic [15:0] wdata_i, rdata_o, trig_in_i, trig_out_o, kick, prev;
	logic [3:0] irq_o;
	logic step_irq_o, wdt_irq_o;
	logic [3:0] irq_log[$];
	int num_errors = 0, check_count = 0, steps = 0, pulses = 0, togs = 0;
	logic [7:0] q1[8] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h20, 8'h10, 8'h30, 8'h01};
	pts_sequencer u_pts_sequencer (.clk_i(clk_i), .rstn_i(rstn_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .idle_i(idle_i), .trig_in_i(trig_in_i),
		.trig_out_o(trig_out_o), .irq_o(irq_o), .step_irq_o(step_irq_o),
		.wdt_irq_o(wdt_irq_o));
	pts_periph_model #(.HOLD(60)) u_pts_periph_model (.clk_i(clk_i),
		.rstn_i(rstn_i), .fall_i(fall), .kick_i(kick), .trig_in_o(trig_in_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		prev <= trig_out_o;
		if (rstn_i && irq_o != 4'h0) irq_log.push_back(irq_o);
		if (rstn_i && step_irq_o) steps++;
		if (rstn_i && trig_out_o[0] && !prev[0]) pulses++;
		if (rstn_i && trig_out_o[2] !== prev[2]) togs++;
	end
	// ---------------------------------------------------------------
	// Register access and comparison helpers
	// ---------------------------------------------------------------
	task automatic complete_run();
		if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(d, e);
	endtask : rchk
	// Status reads back {state one-hot, 0, pc}; WAIT is 8, IDLE is 1.
	task automatic poll(input logic [15:0] e);
		logic [15:0] d;
		d = 16'h0000;
		for (int i = 0; i < 100 && d !== e; i++) rd(PTS_ADDR_STAT, d);
		chk(d, e);
	endtask : poll
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		complete_run();
	end
	initial begin
		{rstn_i, wr_i, rd_i, idle_i, addr_i, wdata_i, kick} = '0;
		fall = 1'b1;
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		rchk(PTS_ADDR_CTRL, PTS_CTRL_RST);
		rchk(PTS_ADDR_CFG, 16'h0010);
		rchk(8'hff, 16'h0000);
		for (int i = 0; i < 8; i++) wr(PTS_ADDR_QUE0 + 8'(i), {8'h00, q1[i]});
		for (int i = 0; i < 8; i++) rchk(PTS_ADDR_QUE0 + 8'(i), 16'(q1[i]));
		wr(PTS_ADDR_CFG, 16'h0021);
		wr(PTS_ADDR_LIM0, 16'h0006);
		wr(PTS_ADDR_WDLIM, 16'h0028);
		wr(PTS_ADDR_CTRL, 16'h8280);
		poll(16'h0085);
		for (int i = 0; i < 4; i++) chk(16'(irq_log[i]), 16'h0001 << i);
		chk(16'(steps), 16'h0005);
		chk(16'(pulses), 16'h0001);
		@(posedge clk_i) kick <= 16'h0001;
		@(posedge clk_i) kick <= 16'h0000;
		poll(16'h0087);
		// The source still holds low here, so only the falling edge can
		// have ended the input wait; rising-edge detection would lag.
		chk(16'(trig_in_i[0]), 16'h0000);
		wr(PTS_ADDR_CTRL, 16'h8280);
		rchk(PTS_ADDR_STAT, 16'h0087);
		wr(PTS_ADDR_CTRL, 16'h8680);
		poll(16'h0085);
		for (int i = 0; i < 200 && wdt_irq_o !== 1'b1; i++) @(posedge clk_i) #1;
		chk(16'(wdt_irq_o), 16'h0001);
		rchk(PTS_ADDR_CTRL, 16'h8240);
		rchk(PTS_ADDR_STAT, 16'h0010);
		wr(PTS_ADDR_CTRL, 16'h0000);
		rchk(PTS_ADDR_CTRL, 16'h0000);
		wr(8'h04, 16'h0001);
		wr(PTS_ADDR_CTRL, 16'h0100);
		rchk(8'h04, 16'h0000);
		wr(PTS_ADDR_CTRL, 16'h0000);
		rchk(8'h04, 16'h0001);
		wr(PTS_ADDR_WDLIM, 16'h0000);
		wr(PTS_ADDR_QUE0, 16'h0022);
		wr(PTS_ADDR_QUE0 + 8'h01, 16'h0040);
		wr(PTS_ADDR_QUE0 + 8'h02, 16'h0010);
		wr(PTS_ADDR_CTRL, 16'h9080);
		poll(16'h0082);
		chk(16'(togs), 16'h0002);
		chk(16'(trig_out_o[2]), 16'h0000);
		wr(PTS_ADDR_CTRL, 16'h0000);
		rchk(PTS_ADDR_STAT, 16'h0010);
		complete_run();
	end
endmodule : tb_pts_sequencer
